// ### src/mms_stage_regs.svh
// Constants for the auxiliary-motor staging controller: encodings, defaults, timing.
// Assumes frequencies in 0.01 Hz, delays and ramp times in 0.1 s, error in 0.01 %.
`ifndef MMS_STAGE_REGS_SVH
`define MMS_STAGE_REGS_SVH

// ==================================================================
// Application mode
`define MMS_APP_MODE_STAGING  4'h3

// ==================================================================
// Setting limits and defaults
`define MMS_AUX_MAX           3'h4
`define MMS_AUX_MAX_NO_EXT    3'h3
`define MMS_AUX_COUNT_RST     3'h4
`define MMS_FIRST_AUX_RST     3'h1
`define MMS_START_FREQ_RST    16'h1387
`define MMS_STOP_FREQ_RST     16'h05DC
`define MMS_DELAY_RST         16'h0258
`define MMS_DELAY_MAX         16'h8CA0
`define MMS_MARGIN_RST        7'h02
`define MMS_RAMP_TIME_RST     13'h0014
`define MMS_MARGIN_SCALE      16'h0064

// ==================================================================
// Timing: delay resolution is one tenth of a second
`define MMS_CLK_PERIOD_NS     4
`define MMS_DELAY_UNIT_NS     100000000
`define MMS_DELAY_UNIT_CYC    (`MMS_DELAY_UNIT_NS / `MMS_CLK_PERIOD_NS)

`endif

// ### src/mms_stage_pkg.sv
// Types shared by the staging controller and its surroundings.
// Assumes the constants header is compiled alongside.
`default_nettype none

package mms_stage_pkg;

  typedef struct packed {
    logic [3:0]  app_mode;
    logic [2:0]  aux_motor_count;
    logic [2:0]  first_aux_select;
    logic [15:0] aux_start_delay;
    logic [15:0] aux_stop_delay;
    logic [6:0]  stage_pressure_margin;
    logic [12:0] main_ramp_up_time;
    logic [12:0] main_ramp_down_time;
  } mms_cfg_t;

  typedef logic [3:0][15:0] mms_freq4_t;

  typedef struct packed {
    logic        active;
    logic        up;
    logic [15:0] target;
    logic [12:0] time_tenths;
  } mms_ramp_t;

  typedef enum logic [2:0] {
    MMS_REGULATE  = 3'b001,
    MMS_RAMP_DOWN = 3'b010,
    MMS_RAMP_UP   = 3'b100
  } mms_state_t;

endpackage : mms_stage_pkg

`default_nettype wire

// ### src/mms_stage.sv
// Staging controller: one speed-regulated main motor plus up to four on/off aux motors.
// Assumes all inputs are synchronous to SYS_CLK and settings are held steady by software.
//
// How it works
// - Staging runs and the option settings are shown only while the app mode equals 3.
// - The main motor stays under feedback control, each aux motor is only switched on or off.
// - Aux outputs are relay 1, relay 2, open collector 1, plus a relay from the extension card.
// - The aux count setting (0 to 4, default 4) limits how many outputs take part.
// - Aux motors start in cyclic order from the first-aux selection (1 to 4).
// - Running aux motors stop in reverse start order, newest first.
// - A running count from zero to the configured number is always readable.
// - Each aux motor has its own start frequency, 0 to 60 Hz, default 49.99 Hz.
// - The next aux starts when speed exceeds its start frequency, delay elapsed, error above margin.
// - Each aux motor has its own stop frequency, 0 to 60 Hz, default 15.00 Hz.
// - The newest aux stops when speed is below its stop frequency, delay elapsed, error below margin.
// - The error is compared against a pressure margin of 0 to 100 percent, default 2.
// - Any aux switch suspends feedback control and runs a plain ramp instead.
// - After a start the main motor ramps down to that motor's stop frequency on the down time.
// - After a stop the main motor ramps up to that motor's start frequency on the up time.
`timescale 1ns/1ns
`default_nettype none
`include "mms_stage_regs.svh"

module mms_stage #(
  parameter int unsigned DELAY_UNIT_CYC = `MMS_DELAY_UNIT_CYC,
  parameter int unsigned AUX_OUTPUTS    = 4
) (
  input  wire logic                    SYS_CLK,
  input  wire logic                    RESET_N,
  input  wire mms_stage_pkg::mms_cfg_t   CFG,
  input  wire mms_stage_pkg::mms_freq4_t AUX_START_FREQ,
  input  wire mms_stage_pkg::mms_freq4_t AUX_STOP_FREQ,
  input  wire logic                    EXT_CARD_PRESENT,
  input  wire logic [15:0]             MAIN_SPEED,
  input  wire logic signed [15:0]      PID_ERROR,
  output logic                         STAGE_ENABLE,
  output logic                         OPTION_PARAM_GROUP,
  output logic [AUX_OUTPUTS-1:0]       AUX_OUT,
  output logic [2:0]                   AUX_RUNNING_COUNT,
  output mms_stage_pkg::mms_ramp_t       RAMP
);

  // ==================================================================
  // Settings decode
  logic        stage_en;
  logic [2:0]  num_eff;
  logic [2:0]  first_idx;
  logic [15:0] margin_scaled;

  assign stage_en = (CFG.app_mode == `MMS_APP_MODE_STAGING);

  always_comb begin
    num_eff = CFG.aux_motor_count;
    if (num_eff > `MMS_AUX_MAX) begin
      num_eff = `MMS_AUX_MAX;
    end
    if (!EXT_CARD_PRESENT && num_eff > `MMS_AUX_MAX_NO_EXT) begin
      num_eff = `MMS_AUX_MAX_NO_EXT;
    end
  end

  assign first_idx     = (CFG.first_aux_select == 3'h0) ? 3'h0 : CFG.first_aux_select - 3'h1;
  assign margin_scaled = 16'({9'h000, CFG.stage_pressure_margin} * `MMS_MARGIN_SCALE);

  // Position k in the rotation, wrapped by the configured motor count
  function automatic logic [2:0] mms_wrap(input logic [2:0] base, input logic [2:0] k,
                                          input logic [2:0] num);
    logic [3:0] s;
    s = {1'b0, base} + {1'b0, k};
    for (int i = 0; i < 3; i++) begin
      if (num != 3'h0 && s >= {1'b0, num}) begin
        s = s - {1'b0, num};
      end
    end
    return s[2:0];
  endfunction : mms_wrap

  // ==================================================================
  // Rotation and conditions
  mms_stage_pkg::mms_state_t state_reg;
  logic [AUX_OUTPUTS-1:0]    aux_reg;
  logic [2:0]                cnt_reg;
  logic [2:0]                next_idx;
  logic [2:0]                last_idx;
  logic [15:0]               start_f;
  logic [15:0]               stop_f;
  logic                      start_cond;
  logic                      stop_cond;
  logic                      start_go;
  logic                      stop_go;
  logic [15:0]               start_tmr_reg;
  logic [15:0]               stop_tmr_reg;
  logic [31:0]               pre_reg;
  logic                      tick;

  assign next_idx = mms_wrap(first_idx, cnt_reg, num_eff);
  assign last_idx = mms_wrap(first_idx, cnt_reg - 3'h1, num_eff);
  assign start_f  = AUX_START_FREQ[next_idx[1:0]];
  assign stop_f   = AUX_STOP_FREQ[last_idx[1:0]];

  assign start_cond = stage_en && cnt_reg < num_eff && MAIN_SPEED > start_f
                      && PID_ERROR > $signed(margin_scaled);
  assign stop_cond  = stage_en && cnt_reg != 3'h0 && MAIN_SPEED < stop_f
                      && PID_ERROR < $signed(margin_scaled);

  assign start_go = state_reg == mms_stage_pkg::MMS_REGULATE && start_cond
                    && start_tmr_reg >= CFG.aux_start_delay;
  assign stop_go  = state_reg == mms_stage_pkg::MMS_REGULATE && !start_go && stop_cond
                    && stop_tmr_reg >= CFG.aux_stop_delay;

  // ==================================================================
  // Tenth-second time base
  assign tick = (pre_reg == DELAY_UNIT_CYC - 1);

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pre_reg <= 32'h0000_0000;
    end else if (tick) begin
      pre_reg <= 32'h0000_0000;
    end else begin
      pre_reg <= pre_reg + 32'h0000_0001;
    end
  end

  // ==================================================================
  // Start and stop delay timers, cleared whenever their condition lapses
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      start_tmr_reg <= 16'h0000;
    end else if (!start_cond || state_reg != mms_stage_pkg::MMS_REGULATE || start_go) begin
      start_tmr_reg <= 16'h0000;
    end else if (tick && start_tmr_reg != `MMS_DELAY_MAX) begin
      start_tmr_reg <= start_tmr_reg + 16'h0001;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      stop_tmr_reg <= 16'h0000;
    end else if (!stop_cond || state_reg != mms_stage_pkg::MMS_REGULATE || stop_go) begin
      stop_tmr_reg <= 16'h0000;
    end else if (tick && stop_tmr_reg != `MMS_DELAY_MAX) begin
      stop_tmr_reg <= stop_tmr_reg + 16'h0001;
    end
  end

  // ==================================================================
  // Aux outputs and running count
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aux_reg <= '0;
      cnt_reg <= 3'h0;
    end else if (!stage_en) begin
      aux_reg <= '0;
      cnt_reg <= 3'h0;
    end else if (start_go) begin
      aux_reg[next_idx[1:0]] <= 1'b1;
      cnt_reg <= cnt_reg + 3'h1;
    end else if (stop_go) begin
      aux_reg[last_idx[1:0]] <= 1'b0;
      cnt_reg <= cnt_reg - 3'h1;
    end
  end

  // ==================================================================
  // Main motor ramp while an aux motor is switched
  mms_stage_pkg::mms_ramp_t ramp_reg;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= mms_stage_pkg::MMS_REGULATE;
      ramp_reg  <= '0;
    end else begin
      case (state_reg)
        mms_stage_pkg::MMS_REGULATE: begin
          if (start_go) begin
            state_reg            <= mms_stage_pkg::MMS_RAMP_DOWN;
            ramp_reg.active      <= 1'b1;
            ramp_reg.up          <= 1'b0;
            ramp_reg.target      <= AUX_STOP_FREQ[next_idx[1:0]];
            ramp_reg.time_tenths <= CFG.main_ramp_down_time;
          end else if (stop_go) begin
            state_reg            <= mms_stage_pkg::MMS_RAMP_UP;
            ramp_reg.active      <= 1'b1;
            ramp_reg.up          <= 1'b1;
            ramp_reg.target      <= AUX_START_FREQ[last_idx[1:0]];
            ramp_reg.time_tenths <= CFG.main_ramp_up_time;
          end
        end
        mms_stage_pkg::MMS_RAMP_DOWN: begin
          if (!stage_en || MAIN_SPEED <= ramp_reg.target) begin
            state_reg       <= mms_stage_pkg::MMS_REGULATE;
            ramp_reg.active <= 1'b0;
          end
        end
        mms_stage_pkg::MMS_RAMP_UP: begin
          if (!stage_en || MAIN_SPEED >= ramp_reg.target) begin
            state_reg       <= mms_stage_pkg::MMS_REGULATE;
            ramp_reg.active <= 1'b0;
          end
        end
        default: begin
          state_reg       <= mms_stage_pkg::MMS_REGULATE;
          ramp_reg.active <= 1'b0;
        end
      endcase
    end
  end

  // ==================================================================
  // Enable flags
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      STAGE_ENABLE       <= 1'b0;
      OPTION_PARAM_GROUP <= 1'b0;
    end else begin
      STAGE_ENABLE       <= stage_en;
      OPTION_PARAM_GROUP <= stage_en;
    end
  end

  assign AUX_OUT           = aux_reg;
  assign AUX_RUNNING_COUNT = cnt_reg;
  assign RAMP              = ramp_reg;

  // ==================================================================
  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_down_reached;
    state_reg == mms_stage_pkg::MMS_RAMP_DOWN ##0 MAIN_SPEED <= ramp_reg.target;
  endsequence

  sequence s_up_reached;
    state_reg == mms_stage_pkg::MMS_RAMP_UP ##0 MAIN_SPEED >= ramp_reg.target;
  endsequence

  a_mode_gate_off: assert property (!stage_en |=> AUX_OUT == '0
                                    && AUX_RUNNING_COUNT == 3'h0)
    else $error("aux outputs active outside staging mode");
  a_count_matches: assert property (AUX_RUNNING_COUNT == 3'($countones(AUX_OUT)))
    else $error("running count differs from outputs on");
  a_ext_relay_off: assert property ((!EXT_CARD_PRESENT && !AUX_OUT[3]) |=> !AUX_OUT[3])
    else $error("extension relay switched without card");
  a_start_limit: assert property (start_go |-> AUX_RUNNING_COUNT < num_eff)
    else $error("start beyond configured aux count");
  a_start_cond_ok: assert property (start_go |-> MAIN_SPEED > start_f
                                    && PID_ERROR > $signed(margin_scaled)
                                    && start_tmr_reg >= CFG.aux_start_delay)
    else $error("aux started without its conditions");
  a_start_step: assert property (start_go |=> AUX_OUT[$past(next_idx[1:0])]
                                 && !$past(AUX_OUT[next_idx[1:0]])
                                 && RAMP.active && !RAMP.up
                                 && RAMP.target == $past(AUX_STOP_FREQ[next_idx[1:0]]))
    else $error("start did not switch the next motor and ramp down");
  a_stop_step: assert property (stop_go |=> !AUX_OUT[$past(last_idx[1:0])]
                                && RAMP.active && RAMP.up
                                && RAMP.target == $past(AUX_START_FREQ[last_idx[1:0]]))
    else $error("stop did not release the newest motor and ramp up");
  a_stop_cond_ok: assert property (stop_go |-> MAIN_SPEED < stop_f
                                   && PID_ERROR < $signed(margin_scaled)
                                   && stop_tmr_reg >= CFG.aux_stop_delay)
    else $error("aux stopped without its conditions");
  a_timer_restart: assert property ((state_reg == mms_stage_pkg::MMS_REGULATE
                                     && !start_cond) |=> start_tmr_reg == 16'h0000)
    else $error("start delay not restarted");
  a_ramp_down_end: assert property (s_down_reached |=> !RAMP.active
                                    && state_reg == mms_stage_pkg::MMS_REGULATE)
    else $error("regulation not resumed after ramp down");
  a_ramp_up_end: assert property (s_up_reached |=> !RAMP.active)
    else $error("regulation not resumed after ramp up");

  // ==================================================================
  // Checks: switching discipline, assuming settings stay steady while motors run
  sequence s_switch;
    start_go || stop_go;
  endsequence

  a_ramp_on_switch: assert property (s_switch |=> RAMP.active
                                     && state_reg != mms_stage_pkg::MMS_REGULATE)
    else $error("switch without suspending regulation");
  a_hold_in_ramp: assert property ((RAMP.active && stage_en)
                                   |=> $stable(AUX_OUT) && $stable(RAMP.target))
    else $error("aux output or ramp target changed during a ramp");
  a_down_time: assert property (start_go
                                |=> RAMP.time_tenths == $past(CFG.main_ramp_down_time))
    else $error("ramp down time not taken from its setting");
  a_up_time: assert property (stop_go
                              |=> RAMP.time_tenths == $past(CFG.main_ramp_up_time))
    else $error("ramp up time not taken from its setting");
  a_stop_newest: assert property (stop_go |-> AUX_OUT[last_idx[1:0]])
    else $error("stop aimed at a motor that is not running");
  a_stop_limit: assert property (stop_go |-> AUX_RUNNING_COUNT != 3'h0)
    else $error("stop with no aux motor running");
  a_count_range: assert property (AUX_RUNNING_COUNT <= `MMS_AUX_MAX)
    else $error("running count above the aux maximum");
  a_stop_restart: assert property ((state_reg == mms_stage_pkg::MMS_REGULATE
                                    && !stop_cond) |=> stop_tmr_reg == 16'h0000)
    else $error("stop delay not restarted");
  a_flags_follow: assert property (1'b1 |=> STAGE_ENABLE == $past(stage_en)
                                   && OPTION_PARAM_GROUP == $past(stage_en))
    else $error("mode flags do not follow the app mode");

endmodule : mms_stage

`default_nettype wire

// ### testbench/mms_motor_model.sv
// Behavioural main motor with its process: speed follows the demand under regulation
// and the reported ramp target while regulation is suspended. Updates on the falling edge.
`timescale 1ns/1ns
`default_nettype none

module mms_motor_model #(
  parameter logic [15:0] STEP = 16'h0032
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire mms_stage_pkg::mms_ramp_t ramp,
  input  wire logic [15:0]              demand,
  output logic [15:0]                   speed
);
  logic [15:0] goal;

  // Ramp target overrides the regulated demand
  assign goal = ramp.active ? ramp.target : demand;

  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) speed <= 16'h0000;
    else if (speed + STEP < goal) speed <= speed + STEP;
    else if (speed > goal + STEP) speed <= speed - STEP;
    else speed <= goal;
  end
endmodule : mms_motor_model

`default_nettype wire

// ### testbench/multi_motor_pump_staging_tb.sv
// Self-checking bench for the staging controller with a behavioural motor model.
// Assumes the package and constants header are compiled first.
`timescale 1ns/1ns
`default_nettype none

module multi_motor_pump_staging_tb;
  localparam int unsigned UNIT = 10;
  logic                      clk, rst_n, ext, en, opt;
  mms_stage_pkg::mms_cfg_t   cfg;
  mms_stage_pkg::mms_freq4_t f_start, f_stop;
  mms_stage_pkg::mms_ramp_t  ramp;
  logic [15:0]               demand, speed;
  logic signed [15:0]        err;
  logic [3:0]                aux, aux_prev;
  logic [2:0]                cnt;
  logic [37:0]               notes[$];
  logic [31:0]               lfsr;
  int                        n_fail, n_tests, cyc;

  mms_stage #(.DELAY_UNIT_CYC(UNIT), .AUX_OUTPUTS(4)) i_mms_stage (
    .SYS_CLK(clk), .RESET_N(rst_n), .CFG(cfg), .AUX_START_FREQ(f_start),
    .AUX_STOP_FREQ(f_stop), .EXT_CARD_PRESENT(ext), .MAIN_SPEED(speed), .PID_ERROR(err),
    .STAGE_ENABLE(en), .OPTION_PARAM_GROUP(opt), .AUX_OUT(aux), .AUX_RUNNING_COUNT(cnt),
    .RAMP(ramp));

  mms_motor_model i_mms_motor_model (
    .clk(clk), .rst_n(rst_n), .ramp(ramp), .demand(demand), .speed(speed));

  // ==================================================================
  // Helpers
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd

  function automatic logic [37:0] note(input logic [3:0] a, input logic [2:0] c,
                                       input logic up, input logic [15:0] tg,
                                       input logic [12:0] tm);
    return {a, c, 1'b1, up, tg, tm};
  endfunction : note

  task automatic check(input logic [37:0] seen, input logic [37:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("n_tests=%0d n_fail=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic drain();
    repeat (3000) if (notes.size() != 0) @(negedge clk);
    check(38'(notes.size()), 38'h0);
  endtask : drain

  // ==================================================================
  // Clock, timeout and output watcher
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    logic [37:0] exp;
    aux_prev = 4'h0;
    forever begin
      @(posedge clk);
      #1;
      if (aux !== aux_prev) begin
        exp = 'x;
        if (notes.size() > 0) exp = notes.pop_front();
        check({aux, cnt, ramp}, exp);
        aux_prev = aux;
      end
    end
  end

  // ==================================================================
  // Main sequence
  initial begin
    int order[3];
    order = '{1, 2, 0};
    rst_n = 1'b0;
    ext = 1'b0;
    demand = 16'h1900;
    err = 16'sh012C;
    lfsr = 32'h00014DE0;
    cfg = '{app_mode: 4'h0, aux_motor_count: 3'h3, first_aux_select: 3'h2,
            aux_start_delay: 16'h0002, aux_stop_delay: 16'h0003,
            stage_pressure_margin: 7'h02, main_ramp_up_time: 13'h0015,
            main_ramp_down_time: 13'h0017};
    for (int i = 0; i < 4; i++) begin
      lfsr = rnd(lfsr);
      f_start[i] = 16'h0FA0 + {5'h00, lfsr[10:0]};
      f_stop[i] = 16'h01F4 + {6'h00, lfsr[25:16]};
    end
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    // Other mode: no staging even with high demand and error
    repeat (300) @(negedge clk);
    check({36'h0, en, opt}, 38'h0);
    // Staging mode, error exactly at the margin: still no start
    cfg.app_mode = 4'h3;
    err = 16'sh00C8;
    repeat (300) @(negedge clk);
    check({36'h0, en, opt}, 38'h3);
    // Load rises: three starts from output 2 cyclically, then no fourth
    for (int k = 0; k < 3; k++)
      notes.push_back(note(4'h2 | (k > 0 ? 4'h4 : 4'h0) | (k > 1 ? 4'h1 : 4'h0), 3'(k + 1),
                           1'b0, f_stop[order[k]], cfg.main_ramp_down_time));
    lfsr = rnd(lfsr);
    err = 16'h00C9 + {8'h00, lfsr[7:0]};
    drain();
    repeat (400) @(negedge clk);
    // Load falls: stops newest first
    for (int k = 2; k >= 0; k--)
      notes.push_back(note((k > 1 ? 4'h2 | 4'h4 : k > 0 ? 4'h2 : 4'h0), 3'(k), 1'b1,
                           f_start[order[k]], cfg.main_ramp_up_time));
    demand = 16'h00C8;
    err = 16'shFED4;
    drain();
    // Start again, then leave staging mode in mid-ramp
    notes.push_back(note(4'h2, 3'h1, 1'b0, f_stop[1], cfg.main_ramp_down_time));
    demand = 16'h1900;
    err = 16'sh012C;
    drain();
    // Leaving staging ends the ramp; target and time stay as last reported
    notes.push_back({7'h00, 2'b00, f_stop[1], cfg.main_ramp_down_time});
    cfg.app_mode = 4'h0;
    drain();
    // Extension card present: four motors from the fourth output, wrapping
    ext = 1'b1;
    cfg.aux_motor_count = 3'h4;
    cfg.first_aux_select = 3'h4;
    cfg.app_mode = 4'h3;
    for (int k = 0; k < 4; k++)
      notes.push_back(note(4'h8 | 4'((1 << k) - 1), 3'(k + 1), 1'b0,
                           f_stop[(k + 3) % 4], cfg.main_ramp_down_time));
    drain();
    complete_run();
  end
endmodule : multi_motor_pump_staging_tb

`default_nettype wire
